/* File: rtl/dfc_pkg.sv */
// Purpose: shared constants of the defect correction control block
// Assumes: 32-bit apb, byte addresses, one aligned word per register
// Notes: field positions follow the control and saturation layouts
package dfc_pkg;
  localparam logic [7:0] ctrl_off = 8'h00;
  localparam logic [7:0] sat_off = 8'h04;
  localparam logic [7:0] readback_off = 8'h08;
  localparam logic [7:0] tbl_ctrl_off = 8'h0C;
  localparam logic [7:0] tbl_data_off = 8'h10;
  localparam int gen_en_pos = 0;
  localparam int line_en_pos = 4;
  localparam int mode_lo = 5;
  localparam int skip_pos = 7;
  localparam int sft_lo = 8;
  localparam int tbl_rd_pos = 3;
  localparam int tbl_busy_pos = 4;
  localparam logic [15:0] ctrl_rst = 16'h0000;
  localparam logic [13:0] sat_rst = 14'h3FFF;
  localparam logic [15:0] readback_rst = 16'h0000;
  localparam logic [1:0] mode_sub = 2'h0;
  localparam logic [1:0] mode_sub_interp = 2'h1;
  localparam logic [1:0] mode_interp = 2'h2;
  localparam int pix_w = 14;
  localparam int fifo_depth = 8;
  localparam int tap_n = 5;
endpackage

/* File: rtl/dfc_ctrl.sv */
// Purpose: defect correction control, saturation test and gain table read-back
// Assumes: pixel and table ports on pclk; frame_vertical_sync is an async pin
// Notes: the interpolation window runs across line ends; edge pixels may mix lines
//
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps

module dfc_fifo #(
  parameter int W = 14,
  parameter int D = 8
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int aw = $clog2(D);
  logic [W-1:0] mem_q [D];
  logic [aw-1:0] wr_q, rd_q;
  logic [aw:0] cnt_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = cnt_q != (aw+1)'(D);
  assign out_valid = cnt_q != '0;
  assign out_data = mem_q[rd_q];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= (wr_q == aw'(D-1)) ? '0 : wr_q + 1'b1;
      if (pop) rd_q <= (rd_q == aw'(D-1)) ? '0 : rd_q + 1'b1;
      cnt_q <= cnt_q + (aw+1)'(push) - (aw+1)'(pop);
    end
  end
  always_ff @(posedge pclk) begin
    if (push) mem_q[wr_q] <= in_data;
  end
endmodule

// What this block does
// - the fetched 16-bit gain table word is readable in a debug register
// - defect level is left shifted by the 3-bit shift amount before subtracting
// - the shifted and subtracted level is the per-defect level input
// - upper pixels skip set leaves pixels above the defect without line correction
// - mode 0 subtracts level but passes saturating pixels unchanged
// - mode 1 subtracts level, saturating pixels get the two-away average
// - mode 2 always interpolates the two-away neighbours; mode 3 reserved
// - line correction enable takes effect at the next vertical sync
// - general correction enable takes effect at the next vertical sync
// - a 14-bit saturation threshold is held and programmable
module dfc_ctrl (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // gain table fetch
  output logic tbl_rd_req,
  input wire logic tbl_rd_valid,
  input wire logic [15:0] tbl_rd_data,
  // frame sync pin
  input wire logic frame_vertical_sync,
  // pixel input
  input wire logic pix_valid,
  output logic pix_ready,
  input wire logic [dfc_pkg::pix_w-1:0] pix_data,
  input wire logic pix_on_line_defect,
  input wire logic pix_above_defect,
  input wire logic pix_general_defect,
  input wire logic [7:0] per_defect_level,
  // pixel output
  output logic out_valid,
  input wire logic out_ready,
  output logic [dfc_pkg::pix_w-1:0] out_data
);
  localparam int pw = dfc_pkg::pix_w;
  // registers
  logic [2:0] sft_q;
  logic skip_q, line_en_q, gen_en_q, line_on_q, gen_on_q;
  logic [1:0] mode_q;
  logic [13:0] sat_q;
  logic [15:0] readback_q;
  logic rd_sel_q, busy_q, req_q;
  logic [31:0] prdata_q;
  logic pready_q, pslverr_q;
  // apb decode
  wire setup = psel && !penable;
  wire wr_go = psel && penable && pready_q && pwrite;
  wire hit_ctrl = paddr == dfc_pkg::ctrl_off;
  wire hit_sat = paddr == dfc_pkg::sat_off;
  wire hit_rb = paddr == dfc_pkg::readback_off;
  wire hit_tc = paddr == dfc_pkg::tbl_ctrl_off;
  wire hit_td = paddr == dfc_pkg::tbl_data_off;
  wire mapped = hit_ctrl || hit_sat || hit_rb || hit_tc || hit_td;
  wire [15:0] ctrl_rd = {5'h00, sft_q, skip_q, mode_q, line_en_q, 3'h0, gen_en_q};
  wire [15:0] tc_rd = {11'h000, busy_q, rd_sel_q, 3'h0};
  wire [31:0] rd_mux = hit_ctrl ? {16'h0000, ctrl_rd} :
                       hit_sat ? {18'h00000, sat_q} :
                       hit_rb ? {16'h0000, readback_q} :
                       hit_tc ? {16'h0000, tc_rd} : 32'h0000_0000;
  // a write to the data port only launches a fetch while read select is set
  wire fetch_go = wr_go && hit_td && rd_sel_q && !busy_q;
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign tbl_rd_req = req_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup && !mapped;
      if (setup) prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sft_q <= dfc_pkg::ctrl_rst[dfc_pkg::sft_lo +: 3];
      skip_q <= dfc_pkg::ctrl_rst[dfc_pkg::skip_pos];
      mode_q <= dfc_pkg::ctrl_rst[dfc_pkg::mode_lo +: 2];
      line_en_q <= dfc_pkg::ctrl_rst[dfc_pkg::line_en_pos];
      gen_en_q <= dfc_pkg::ctrl_rst[dfc_pkg::gen_en_pos];
      sat_q <= dfc_pkg::sat_rst;
      rd_sel_q <= 1'b0;
    end else if (wr_go) begin
      if (hit_ctrl) begin
        sft_q <= pwdata[dfc_pkg::sft_lo +: 3];
        skip_q <= pwdata[dfc_pkg::skip_pos];
        mode_q <= pwdata[dfc_pkg::mode_lo +: 2];
        line_en_q <= pwdata[dfc_pkg::line_en_pos];
        gen_en_q <= pwdata[dfc_pkg::gen_en_pos];
      end
      if (hit_sat) sat_q <= pwdata[13:0];
      if (hit_tc) rd_sel_q <= pwdata[dfc_pkg::tbl_rd_pos];
    end
  end
  // table fetch: busy from the data port write until the word returns
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q <= 1'b0;
      req_q <= 1'b0;
      readback_q <= dfc_pkg::readback_rst;
    end else begin
      req_q <= fetch_go;
      if (fetch_go) busy_q <= 1'b1;
      else if (tbl_rd_valid) busy_q <= 1'b0;
      if (busy_q && tbl_rd_valid) readback_q <= tbl_rd_data;
    end
  end
  // frame sync: three stages, an edge counts when stage two is high and stage three still low
  logic [2:0] vs_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) vs_q <= 3'h0;
    else vs_q <= {vs_q[1:0], frame_vertical_sync};
  end
  wire vs_rise = vs_q[1] && !vs_q[2];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_on_q <= 1'b0;
      gen_on_q <= 1'b0;
    end else if (vs_rise) begin
      line_on_q <= line_en_q;
      gen_on_q <= gen_en_q;
    end
  end
  // pixel window; the fifo's ready stalls the whole window
  // the incoming pixel is the right-hand tap, so four stored pixels fill the window
  logic [pw-1:0] win_q [dfc_pkg::tap_n - 1];
  logic [10:0] side_q [2];
  logic [2:0] fill_q;
  logic fifo_ready;
  wire shift = pix_valid && fifo_ready;
  wire win_full = fill_q == 3'(dfc_pkg::tap_n - 1);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) fill_q <= 3'h0;
    else if (shift && !win_full) fill_q <= fill_q + 3'h1;
  end
  always_ff @(posedge pclk) begin
    if (shift) begin
      win_q[0] <= pix_data;
      side_q[0] <= {pix_on_line_defect, pix_above_defect, pix_general_defect, per_defect_level};
      for (int i = 1; i < dfc_pkg::tap_n - 1; i++) win_q[i] <= win_q[i-1];
      for (int i = 1; i < 2; i++) side_q[i] <= side_q[i-1];
    end
  end
  assign pix_ready = fifo_ready;
  // correction of the centre pixel
  wire [pw-1:0] cur = win_q[1];
  wire c_line = side_q[1][10];
  wire c_above = side_q[1][9];
  wire c_gen = side_q[1][8];
  wire [7:0] c_level = side_q[1][7:0];
  wire [pw-1:0] shifted = pw'({6'h00, c_level} << sft_q);
  // level above the pixel clamps to zero rather than wrapping
  wire [pw-1:0] sub = (cur > shifted) ? cur - shifted : '0;
  wire [pw:0] pair_sum = {1'b0, win_q[3]} + {1'b0, pix_data};
  wire [pw-1:0] interp = pair_sum[pw:1];
  wire sat = cur >= sat_q;
  wire line_act = line_on_q && c_line && !(skip_q && c_above);
  wire [pw-1:0] line_val = (mode_q == dfc_pkg::mode_sub) ? (sat ? cur : sub) :
                           (mode_q == dfc_pkg::mode_sub_interp) ? (sat ? interp : sub) :
                           (mode_q == dfc_pkg::mode_interp) ? interp : cur;
  wire [pw-1:0] corr = line_act ? line_val : (gen_on_q && c_gen) ? interp : cur;
  wire push = shift && win_full;
  dfc_fifo #(.W(pw), .D(dfc_pkg::fifo_depth)) out_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(push),
    .in_ready(fifo_ready),
    .in_data(corr),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(out_data)
  );

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  line_latch_a: assert property (!vs_rise |=> $stable(line_on_q))
    else $error("line enable moved without sync");
  gen_latch_a: assert property (vs_rise |=> gen_on_q == $past(gen_en_q))
    else $error("general enable not taken at sync");
  mode0_sat_a: assert property (line_act && mode_q == 2'h0 && sat |-> corr == cur)
    else $error("saturating pixel altered in mode 0");
  mode1_sat_a: assert property (line_act && mode_q == 2'h1 && sat |->
    2*corr + 15'(pair_sum[0]) == pair_sum)
    else $error("mode 1 saturating pixel not averaged");
  mode2_interp_a: assert property (line_act && mode_q == 2'h2 |->
    corr <= win_q[3] || corr <= pix_data)
    else $error("mode 2 output outside neighbours");
  upper_skip_a: assert property (skip_q && c_above && !(gen_on_q && c_gen) |-> corr == cur)
    else $error("pixel above defect corrected");
  level_shift_a: assert property (line_act && mode_q == 2'h0 && !sat && cur >= 14'h3FC0 |->
    cur - corr == 14'(c_level) * (14'h0001 << sft_q))
    else $error("defect level shift wrong");
  sat_thr_a: assert property (line_act && mode_q == 2'h0 && cur < sat_q && cur > shifted |->
    corr < cur || shifted == '0)
    else $error("pixel below threshold not subtracted");
  readback_a: assert property (busy_q && tbl_rd_valid |=> readback_q == $past(tbl_rd_data) && !busy_q)
    else $error("table word not captured");
  reserved_a: assert property (pready_q && psel && !pwrite && hit_ctrl |-> prdata_q[15:11] == 5'h00 && prdata_q[3:1] == 3'h0)
    else $error("reserved control bits not zero");

  // register bus and fetch handshake
  apb_ready_a: assert property (setup |=> pready_q)
    else $error("no ready after setup");
  slverr_a: assert property (setup && !mapped |=> pslverr_q && prdata_q == 32'h0000_0000)
    else $error("unmapped access not flagged");
  rd_sat_a: assert property (setup && !pwrite && hit_sat |=> prdata_q[13:0] == $past(sat_q))
    else $error("threshold read back wrong");
  sat_write_a: assert property (wr_go && hit_sat |=> sat_q == $past(pwdata[13:0]))
    else $error("threshold write lost");
  fetch_start_a: assert property (fetch_go |=> req_q && busy_q)
    else $error("fetch not launched");
  req_pulse_a: assert property (req_q |=> !req_q)
    else $error("fetch request longer than one cycle");
  busy_hold_a: assert property (busy_q && !tbl_rd_valid |=> busy_q)
    else $error("busy dropped before word returned");
  readback_hold_a: assert property (!(busy_q && tbl_rd_valid) |=> $stable(readback_q))
    else $error("readback changed without a fetch");
  // enable latching: a write alone must never reach the datapath
  line_take_a: assert property (vs_rise |=> line_on_q == $past(line_en_q))
    else $error("line enable not taken at sync");
  gen_hold_a: assert property (!vs_rise |=> $stable(gen_on_q))
    else $error("general enable moved without sync");
  // correction datapath
  mode3_pass_a: assert property (line_act && mode_q == 2'h3 |-> corr == cur)
    else $error("reserved mode altered pixel");
  line_off_a: assert property (!line_on_q && !(gen_on_q && c_gen) |-> corr == cur)
    else $error("pixel corrected with correction off");
  general_a: assert property (!line_act && gen_on_q && c_gen |->
    2*corr + 15'(pair_sum[0]) == pair_sum)
    else $error("general defect not interpolated");
  shift_zero_a: assert property (line_act && mode_q == 2'h0 && !sat && sft_q == 3'h0 |->
    corr == ((cur > 14'(c_level)) ? cur - 14'(c_level) : 14'h0000))
    else $error("unshifted level not subtracted");
  // a full buffer must hold the window still, never drop a pixel
  full_stall_a: assert property (!fifo_ready |-> !push)
    else $error("push into full buffer");
  sat_cov_c: cover property (push && line_act && mode_q == 2'h1 && sat);
  mode2_cov_c: cover property (push && line_act && mode_q == 2'h2);
  full_cov_c: cover property (!fifo_ready);
  fetch_cov_c: cover property (fetch_go ##[1:20] !busy_q);
  sync_cov_c: cover property (vs_rise ##1 line_on_q);
endmodule

/* File: tb/gain_table_model.sv */
// Purpose: gain table responder on the fetch port
// Assumes: one fetch outstanding at a time
// Notes: answers alternate prompt and slow; idle data toggles so stale words show
`timescale 1ns/1ps
module gain_table_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // fetch port
  input wire logic tbl_rd_req,
  output logic tbl_rd_valid,
  output logic [15:0] tbl_rd_data
);
  int wait_q;
  int n_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_q <= 0;
      n_q <= 0;
      tbl_rd_valid <= 1'b0;
      tbl_rd_data <= 16'h0000;
    end else if (tbl_rd_req) begin
      wait_q <= (n_q % 2 == 1) ? 6 : 1;
      tbl_rd_valid <= 1'b0;
    end else if (wait_q == 1) begin
      wait_q <= 0;
      n_q <= n_q + 1;
      tbl_rd_valid <= 1'b1;
      tbl_rd_data <= 16'hA5C3 + 16'(n_q) * 16'h1111;
    end else begin
      wait_q <= (wait_q > 0) ? wait_q - 1 : 0;
      tbl_rd_valid <= 1'b0;
      tbl_rd_data <= ~tbl_rd_data;
    end
  end
endmodule

/* File: tb/sensor_defect_correction_ctrl_bench.sv */
// Purpose: register, table fetch and pixel correction checks of dfc_ctrl
// Assumes: enables latch within 8 cycles of a sync rise
// Notes: expectations come from the bench's own copy of the configuration
`timescale 1ns/1ps
module sensor_defect_correction_ctrl_bench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic tbl_rd_req, tbl_rd_valid, frame_vertical_sync, pix_valid, pix_ready, out_valid, out_ready;
  logic pix_on_line_defect, pix_above_defect, pix_general_defect;
  logic [7:0] paddr, per_defect_level;
  logic [31:0] pwdata, prdata, rdv;
  logic [15:0] tbl_rd_data;
  logic [13:0] pix_data, out_data, c_thr;
  logic [13:0] exp_q[$];
  logic w_line, w_gen, c_line, c_gen, c_skip;
  logic [1:0] c_mode;
  logic [2:0] c_sft;
  int n_fail, samples_checked, np, nf, t;
  dfc_ctrl u_dfc_ctrl (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .tbl_rd_req, .tbl_rd_valid, .tbl_rd_data, .frame_vertical_sync,
    .pix_valid, .pix_ready, .pix_data, .pix_on_line_defect, .pix_above_defect,
    .pix_general_defect, .per_defect_level, .out_valid, .out_ready, .out_data);
  gain_table_model u_gain_table_model (.pclk, .presetn, .tbl_rd_req, .tbl_rd_valid, .tbl_rd_data);
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  function automatic logic [13:0] pv(int i);
    return 14'((i * 2621) % 16384);
  endfunction
  function automatic logic [7:0] lv(int i);
    return 8'((i * 37) % 256);
  endfunction
  function automatic logic [13:0] ev(int i);
    logic [14:0] sh, mid;
    sh = 15'(lv(i)) << c_sft;
    mid = (15'(pv(i - 2)) + 15'(pv(i + 2))) >> 1;
    if (c_line && (i & 3) != 0 && !(c_skip && (i & 4) != 0)) begin
      if (c_mode == 2'h2 || (c_mode == 2'h1 && pv(i) >= c_thr)) return mid[13:0];
      if (c_mode == 2'h3 || pv(i) >= c_thr) return pv(i);
      return (15'(pv(i)) > sh) ? 14'(15'(pv(i)) - sh) : 14'h0000;
    end
    if (c_gen && (i & 8) != 0) return mid[13:0];
    return pv(i);
  endfunction
  task automatic summarize;
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic hang;
    n_fail++;
    $display("BAD wait expected done seen timeout");
    summarize();
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) hang();
    rdv = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e, string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rdv);
  endtask
  task automatic cfg(logic ln, logic gn, logic [1:0] m, logic [2:0] s, logic k);
    apb(1'b1, dfc_pkg::ctrl_off, {21'h0, s, k, m, ln, 3'h0, gn});
    {w_line, w_gen, c_mode, c_sft, c_skip} = {ln, gn, m, s, k};
  endtask
  task automatic sat(logic [13:0] v);
    apb(1'b1, dfc_pkg::sat_off, {18'h0, v});
    c_thr = v;
  endtask
  task automatic vs;
    frame_vertical_sync <= 1'b1;
    repeat (2) @(posedge pclk);
    frame_vertical_sync <= 1'b0;
    repeat (6) @(posedge pclk);
    {c_line, c_gen} = {w_line, w_gen};
  endtask
  task automatic burst(int n);
    int k;
    repeat (n) begin
      pix_valid <= 1'b1;
      pix_data <= pv(np);
      pix_on_line_defect <= (np & 3) != 0;
      pix_above_defect <= (np & 4) != 0;
      pix_general_defect <= (np & 8) != 0;
      per_defect_level <= lv(np);
      for (k = 0; k < 50; k++) begin
        @(posedge pclk);
        if (pix_ready === 1'b1) break;
      end
      if (k == 50) hang();
      if (np >= 4) exp_q.push_back(ev(np - 2));
      np++;
    end
    pix_valid <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic drain;
    for (t = 0; t < 200 && exp_q.size() > 0; t++) @(posedge pclk);
    if (t == 200) hang();
  endtask
  always @(posedge pclk) begin
    if (out_valid === 1'b1 && out_ready === 1'b1) begin
      if (exp_q.size() == 0) chk("extra pixel", 32'h0, 32'h1);
      else chk("pixel", 32'(exp_q.pop_front()), 32'(out_data));
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, frame_vertical_sync, pix_valid} = '0;
    {pix_data, pix_on_line_defect, pix_above_defect, pix_general_defect, per_defect_level} = '0;
    {c_line, c_gen, c_mode, c_sft, c_skip, c_thr} = '0;
    out_ready = 1'b1;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(dfc_pkg::ctrl_off, 32'h0, "ctrl reset");
    rd(dfc_pkg::sat_off, 32'h3FFF, "sat reset");
    rd(dfc_pkg::readback_off, 32'h0, "readback reset");
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped err", 32'h1, 32'(er));
    apb(1'b1, dfc_pkg::ctrl_off, 32'hFFFF_FEFF);
    rd(dfc_pkg::ctrl_off, 32'h06F1, "ctrl mask");
    sat(14'h3FFF);
    rd(dfc_pkg::sat_off, 32'h3FFF, "sat mask");
    $display("test registers done");
    apb(1'b1, dfc_pkg::tbl_ctrl_off, 32'h8);
    for (nf = 0; nf < 2; nf++) begin
      apb(1'b1, dfc_pkg::tbl_data_off, 32'h1234);
      for (t = 0; t < 40; t++) begin
        apb(1'b0, dfc_pkg::tbl_ctrl_off, 32'h0);
        if (rdv[4] === 1'b0) break;
      end
      if (t == 40) hang();
      rd(dfc_pkg::readback_off, 32'(16'hA5C3 + 16'(nf) * 16'h1111), "readback");
    end
    $display("test table done");
    cfg(1'b1, 1'b1, 2'h0, 3'h0, 1'b0);
    sat(14'd8000);
    burst(8);
    vs();
    burst(8);
    $display("test latch done");
    for (int m = 0; m < 4; m++) begin
      for (int s = 0; s < 7; s += 6) begin
        cfg(1'b1, 1'b1, 2'(m), 3'(s), s != 0);
        sat(pv(np + 2));
        burst(6);
      end
    end
    cfg(1'b0, 1'b1, 2'h1, 3'h0, 1'b0);
    vs();
    burst(8);
    $display("test modes done");
    drain();
    out_ready <= 1'b0;
    burst(8);
    chk("fifo full", 32'h0, 32'(pix_ready));
    out_ready <= 1'b1;
    drain();
    @(posedge pclk);
    chk("fifo empty", 32'h0, 32'(out_valid));
    $display("test buffer done");
    summarize();
  end
endmodule
